// File: dv/lodp_load.sv
// Contactor or brake coil load seen by the two logic output pins
module lodp_load (
   input wire logic clock,
   input wire logic logic_out_a,
   input wire logic logic_out_b,
   output logic coil_a,
   output logic coil_b
);
   timeunit 1ns;
   timeprecision 100ps;
   // Coils pull in one clock after the pin, like a slow relay armature
   always_ff @(posedge clock) begin
      coil_a <= logic_out_a;
      coil_b <= logic_out_b;
   end
endmodule : lodp_load

// File: dv/logic_output_delay_polarity_bench.sv
`define CHK(a, e) \
   begin \
      checked++; \
      if ((a) !== (e)) begin \
         failures++; \
         $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module logic_output_delay_polarity_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // Short tick so millisecond counts stay cheap in simulation
   localparam int TK = 4;
   logic clock, srst, clk_en, card, brk, line, ap_a, ap_b, pa, pb;
   logic pin_a, pin_b, cfg_av, pol_a, pol_b, coil_a, coil_b;
   logic [63:0] cv;
   logic [5:0] src_a, src_b, se_a, se_b;
   logic [13:0] dl_a, hd_a, dl_b, hd_b;
   int failures = 0;
   int checked = 0;
   lodp_top #(.TICK_CYC(TK)) dut (.clock(clock), .srst(srst),
      .clk_en(clk_en), .card_fitted(card), .cond_vec(cv),
      .brake_ctrl_source(brk), .line_contactor_source(line),
      .out_a_source(src_a), .out_a_app_brake(ap_a),
      .out_a_turn_on_delay(dl_a), .out_a_hold_time(hd_a),
      .out_a_active_high(pa), .out_b_source(src_b),
      .out_b_app_brake(ap_b), .out_b_turn_on_delay(dl_b),
      .out_b_hold_time(hd_b), .out_b_active_high(pb),
      .logic_out_a(pin_a), .logic_out_b(pin_b), .cfg_available(cfg_av),
      .out_a_source_eff(se_a), .out_b_source_eff(se_b),
      .out_a_polarity_eff(pol_a), .out_b_polarity_eff(pol_b));
   lodp_load load (.clock(clock), .logic_out_a(pin_a),
      .logic_out_b(pin_b), .coil_a(coil_a), .coil_b(coil_b));
   // Free-running clock, 5 ns period
   initial begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   // Inputs move on falling edges, away from sampling
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask : step
   // Prints the counts and the verdict, then ends the run
   task automatic tally_and_finish;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   // Turn-on delay 2 ms then hold 3 ms on output a
   task automatic t_delay_hold;
      src_a = 6'h05;
      dl_a = 14'h0002;
      hd_a = 14'h0003;
      cv[5] = 1'h1;
      step(4);
      `CHK(pin_a, 1'h0)
      step(5);
      `CHK(pin_a, 1'h1)
      `CHK(coil_a, 1'h1)
      cv[5] = 1'h0;
      step(8);
      `CHK(pin_a, 1'h1)
      step(5);
      `CHK(pin_a, 1'h0)
   endtask : t_delay_hold
   // A short blip must not shorten the next turn-on wait
   task automatic t_restart;
      cv[5] = 1'h1;
      step(5);
      cv[5] = 1'h0;
      step(1);
      cv[5] = 1'h1;
      step(4);
      `CHK(pin_a, 1'h0)
      step(5);
      `CHK(pin_a, 1'h1)
      hd_a = 14'h0000;
      cv[5] = 1'h0;
      step(2);
      `CHK(pin_a, 1'h0)
   endtask : t_restart
   // Inverted polarity, no assignment, brake code without app brake
   task automatic t_polarity;
      pb = 1'h0;
      src_b = lodp_pkg::SRC_BRAKE;
      step(2);
      `CHK(pin_b, 1'h1)
      `CHK(pol_b, 1'h0)
      `CHK(se_b, lodp_pkg::SRC_NONE)
   endtask : t_polarity
   // Brake on a, line contactor on b: no timing, forced active high
   task automatic t_brake_line;
      ap_a = 1'h1;
      src_a = lodp_pkg::SRC_BRAKE;
      pa = 1'h0;
      dl_a = 14'h3fff;
      hd_a = 14'h3fff;
      src_b = lodp_pkg::SRC_LINE;
      dl_b = 14'h270f;
      hd_b = 14'h270f;
      step(1);
      `CHK(pol_a, 1'h1)
      `CHK(pol_b, 1'h1)
      `CHK(se_a, lodp_pkg::SRC_BRAKE)
      brk = 1'h1;
      line = 1'h1;
      step(2);
      `CHK(({pin_a, pin_b}), 2'h3)
      `CHK(coil_b, 1'h1)
      brk = 1'h0;
      line = 1'h0;
      step(2);
      `CHK(({pin_a, pin_b}), 2'h0)
   endtask : t_brake_line
   // Card pulled: settings unavailable and pin a dropped
   task automatic t_card;
      brk = 1'h1;
      step(2);
      card = 1'h0;
      step(2);
      `CHK(cfg_av, 1'h0)
      `CHK(pin_a, 1'h0)
   endtask : t_card
   // Clock enable freeze, then a reset in mid-run
   task automatic t_freeze_reset;
      card = 1'h1;
      ap_a = 1'h0;
      src_a = 6'h05;
      pa = 1'h1;
      dl_a = 14'h0000;
      hd_a = 14'h0000;
      brk = 1'h0;
      cv[5] = 1'h1;
      clk_en = 1'h0;
      step(3);
      `CHK(pin_a, 1'h0)
      clk_en = 1'h1;
      step(1);
      `CHK(pin_a, 1'h1)
      srst = 1'h1;
      step(1);
      `CHK(pin_a, 1'h0)
      srst = 1'h0;
      step(1);
      `CHK(pin_a, 1'h1)
   endtask : t_freeze_reset
   // Main sequence from factory settings
   initial begin
      srst = 1'h1;
      clk_en = 1'h1;
      card = 1'h1;
      cv = 64'h0;
      brk = 1'h0;
      line = 1'h0;
      ap_a = 1'h0;
      ap_b = 1'h0;
      src_a = lodp_pkg::SRC_RST;
      src_b = lodp_pkg::SRC_RST;
      dl_a = lodp_pkg::DELAY_RST;
      hd_a = lodp_pkg::HOLD_RST;
      dl_b = lodp_pkg::DELAY_RST;
      hd_b = lodp_pkg::HOLD_RST;
      pa = lodp_pkg::POL_RST;
      pb = lodp_pkg::POL_RST;
      step(4);
      srst = 1'h0;
      step(2);
      `CHK(({pin_a, pin_b, cfg_av}), 3'h1)
      t_delay_hold();
      t_restart();
      t_polarity();
      t_brake_line();
      t_card();
      t_freeze_reset();
      tally_and_finish();
   end
   // Hang guard, far beyond the 62 cycles the tests use
   initial begin
      #(20000 * 5);
      failures++;
      tally_and_finish();
   end
endmodule : logic_output_delay_polarity_bench

// File: src/lodp_pkg.sv
package lodp_pkg;
   // Clock rate and millisecond tick
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // Number of logic outputs on the option card
   localparam int N_OUT = 2;
   // Source selector width and number of assignable conditions
   localparam int SRC_W = 6;
   localparam int N_COND = 64;
   // Timer field width and settable ceiling
   localparam int MS_W = 14;
   localparam logic [13:0] MS_MAX = 14'h270f;
   // Selector codes with a fixed meaning
   localparam logic [5:0] SRC_NONE = 6'h00;
   localparam logic [5:0] SRC_BRAKE = 6'h3f;
   localparam logic [5:0] SRC_LINE = 6'h3e;
   // Factory settings
   localparam logic [13:0] DELAY_RST = 14'h0000;
   localparam logic [13:0] HOLD_RST = 14'h0000;
   localparam logic POL_RST = 1'h1;
   localparam logic [5:0] SRC_RST = 6'h00;
endpackage : lodp_pkg

// File: src/lodp_top.sv
module lodp_top #(
   parameter int TICK_CYC = lodp_pkg::MS_TICK_CYC
) (
   input wire logic clock,
   input wire logic srst,
   // Freezes all state while low
   input wire logic clk_en,
   // Option card presence
   input wire logic card_fitted,
   // Assignable conditions, bit 0 unused (no assignment)
   input wire logic [lodp_pkg::N_COND-1:0] cond_vec,
   // Brake and line contactor conditions
   input wire logic brake_ctrl_source,
   input wire logic line_contactor_source,
   // Output a settings
   input wire logic [lodp_pkg::SRC_W-1:0] out_a_source,
   input wire logic out_a_app_brake,
   input wire logic [lodp_pkg::MS_W-1:0] out_a_turn_on_delay,
   input wire logic [lodp_pkg::MS_W-1:0] out_a_hold_time,
   input wire logic out_a_active_high,
   // Output b settings
   input wire logic [lodp_pkg::SRC_W-1:0] out_b_source,
   input wire logic out_b_app_brake,
   input wire logic [lodp_pkg::MS_W-1:0] out_b_turn_on_delay,
   input wire logic [lodp_pkg::MS_W-1:0] out_b_hold_time,
   input wire logic out_b_active_high,
   // Pins and readback of effective settings
   output logic logic_out_a,
   output logic logic_out_b,
   output logic cfg_available,
   output logic [lodp_pkg::SRC_W-1:0] out_a_source_eff,
   output logic [lodp_pkg::SRC_W-1:0] out_b_source_eff,
   output logic out_a_polarity_eff,
   output logic out_b_polarity_eff
);
   localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   localparam int N = lodp_pkg::N_OUT;

   // Whole state of the block
   typedef struct packed {
      logic [TW-1:0] tick;                // Millisecond prescaler
      logic [N-1:0] st;                   // Filtered condition
      logic [N-1:0] pin;                  // Registered pin level
      logic [N-1:0][lodp_pkg::MS_W-1:0] cnt; // Elapsed ms
   } lodp_state_s;

   lodp_state_s state_reg;
   lodp_state_s state_next;

   // Per-output views of the loose ports
   logic [N-1:0][lodp_pkg::SRC_W-1:0] src_req;
   logic [N-1:0] app_brk;
   logic [N-1:0][lodp_pkg::MS_W-1:0] dly_req;
   logic [N-1:0][lodp_pkg::MS_W-1:0] hld_req;
   logic [N-1:0] pol_req;
   // Effective settings after forcing and clamping
   logic [N-1:0][lodp_pkg::SRC_W-1:0] src_eff;
   logic [N-1:0][lodp_pkg::MS_W-1:0] dly_eff;
   logic [N-1:0][lodp_pkg::MS_W-1:0] hld_eff;
   logic [N-1:0] pol_eff;
   logic [N-1:0] forced;               // Brake or contactor source
   logic [N-1:0] cond;                 // Selected raw condition
   logic tick;                         // One-cycle ms strobe

   assign src_req = {out_b_source, out_a_source};
   assign app_brk = {out_b_app_brake, out_a_app_brake};
   assign dly_req = {out_b_turn_on_delay, out_a_turn_on_delay};
   assign hld_req = {out_b_hold_time, out_a_hold_time};
   assign pol_req = {out_b_active_high, out_a_active_high};

   assign tick = (state_reg.tick == TW'(TICK_CYC - 1));

   // Effective configuration per output
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_out
         // Brake only comes from the application functions side;
         // a brake code on the I/O selector alone means nothing
         always_comb begin
            if (app_brk[g]) begin
               src_eff[g] = lodp_pkg::SRC_BRAKE;
            end else if (src_req[g] == lodp_pkg::SRC_BRAKE) begin
               src_eff[g] = lodp_pkg::SRC_NONE;
            end else begin
               src_eff[g] = src_req[g];
            end
         end
         assign forced[g] = (src_eff[g] == lodp_pkg::SRC_BRAKE) ||
                            (src_eff[g] == lodp_pkg::SRC_LINE);
         // Clamp to the settable range, force for contactor use
         assign dly_eff[g] = forced[g] ? '0 :
            ((dly_req[g] > lodp_pkg::MS_MAX) ? lodp_pkg::MS_MAX
                                               : dly_req[g]);
         assign hld_eff[g] = forced[g] ? '0 :
            ((hld_req[g] > lodp_pkg::MS_MAX) ? lodp_pkg::MS_MAX
                                               : hld_req[g]);
         assign pol_eff[g] = forced[g] ? 1'h1 : pol_req[g];
         // Condition mux; code zero is the unassigned state
         always_comb begin
            if (src_eff[g] == lodp_pkg::SRC_BRAKE) begin
               cond[g] = brake_ctrl_source;
            end else if (src_eff[g] == lodp_pkg::SRC_LINE) begin
               cond[g] = line_contactor_source;
            end else if (src_eff[g] == lodp_pkg::SRC_NONE) begin
               cond[g] = 1'h0;
            end else begin
               cond[g] = cond_vec[src_eff[g]];
            end
         end
      end
   endgenerate

   // Next-state logic for prescaler, filters and pins
   always_comb begin
      logic [lodp_pkg::MS_W-1:0] tgt; // Time the pending change needs
      tgt = '0;
      state_next = state_reg;
      // Prescaler keeps running so tick phase is independent of
      // condition edges; a delay is therefore exact to within 1 ms
      state_next.tick = tick ? '0 : TW'(state_reg.tick + 1'h1);
      for (int i = 0; i < N; i++) begin
         // Delay while turning on, holding time while turning off
         tgt = cond[i] ? dly_eff[i] : hld_eff[i];
         if (!card_fitted) begin
            // Card absent: pin parked low, filter idle
            state_next.st[i] = 1'h0;
            state_next.cnt[i] = '0;
         end else if (cond[i] == state_reg.st[i]) begin
            // Nothing pending: a half-run timer is thrown away
            state_next.cnt[i] = '0;
         end else if (tgt == '0) begin
            // Zero time: follow at once
            state_next.st[i] = cond[i];
            state_next.cnt[i] = '0;
         end else if (tick) begin
            // Incremented value is compared, so cnt stays below target
            if (state_reg.cnt[i] + 1'h1 >= tgt) begin
               state_next.st[i] = cond[i];
               state_next.cnt[i] = '0;
            end else begin
               state_next.cnt[i] = state_reg.cnt[i] + 1'h1;
            end
         end
         // Pin from the next filtered state and active level
         state_next.pin[i] = card_fitted &&
            (state_next.st[i] ? pol_eff[i] : !pol_eff[i]);
      end
   end

   // State register with clock enable and synchronous reset
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= '0;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // Pins straight from flip-flops, readback is combinational
   assign logic_out_a = state_reg.pin[0];
   assign logic_out_b = state_reg.pin[1];
   assign cfg_available = card_fitted;
   assign out_a_source_eff = src_eff[0];
   assign out_b_source_eff = src_eff[1];
   assign out_a_polarity_eff = pol_eff[0];
   assign out_b_polarity_eff = pol_eff[1];

   // Checks on both outputs
   // Quiet through reset; checks on timing name clk_en themselves
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   generate
      for (g = 0; g < N; g++) begin : g_chk
         a_card_absent_low: assert property (
            clk_en && !card_fitted |=> !state_reg.pin[g])
            else $error("pin not low without card");
         a_brake_from_app: assert property (
            src_eff[g] == lodp_pkg::SRC_BRAKE |-> app_brk[g])
            else $error("brake source without app request");
         a_delay_holds_off: assert property (
            clk_en && card_fitted && cond[g] && !state_reg.st[g] &&
            dly_eff[g] != '0 && !tick |=> !state_reg.st[g])
            else $error("turn-on ahead of delay");
         a_hold_keeps_on: assert property (
            clk_en && card_fitted && !cond[g] && state_reg.st[g] &&
            hld_eff[g] != '0 && !tick |=> state_reg.st[g])
            else $error("turn-off ahead of holding time");
         a_pin_polarity: assert property (
            clk_en && card_fitted |=>
            state_reg.pin[g] == (state_reg.st[g] ~^ $past(pol_eff[g])))
            else $error("pin level mismatches polarity");
         a_forced_no_delay: assert property (
            clk_en && card_fitted && forced[g] |=>
            state_reg.st[g] == $past(cond[g]))
            else $error("contactor output delayed");
         a_forced_pol_high: assert property (
            forced[g] |-> pol_eff[g])
            else $error("contactor polarity not high");
         a_forced_no_hold: assert property (
            forced[g] |-> hld_eff[g] == '0 && dly_eff[g] == '0)
            else $error("contactor holding not zero");
         a_timer_restart: assert property (
            clk_en && cond[g] == state_reg.st[g] |=>
            state_reg.cnt[g] == '0)
            else $error("timer not restarted");
         c_delayed_on: cover property (
            state_reg.cnt[g] != '0 ##1 $rose(state_reg.st[g]));
         c_held_off: cover property (
            state_reg.cnt[g] != '0 ##1 $fell(state_reg.st[g]));
         c_brake_out: cover property (
            forced[g] && $rose(state_reg.pin[g]));
         // Clamped settings never leave the settable range
         a_delay_ceiling: assert property (
            dly_eff[g] <= lodp_pkg::MS_MAX)
            else $error("turn-on delay above ceiling");
         a_hold_ceiling: assert property (
            hld_eff[g] <= lodp_pkg::MS_MAX)
            else $error("holding time above ceiling");
         // Unassigned output sees a permanently false condition
         a_unassigned_false: assert property (
            src_eff[g] == lodp_pkg::SRC_NONE |-> !cond[g])
            else $error("unassigned output sees a condition");
         c_card_pulled: cover property (
            $fell(card_fitted) ##1 !state_reg.pin[g]);
      end
   endgenerate
endmodule : lodp_top
